// ---- testbench/host_loader.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// host side of the load pins
// ****************************************
module host_loader (
  // load pins
  output logic       word_load_clk_out,
  output logic       strobe_out,
  output logic [7:0] data_out
);
  initial begin
    word_load_clk_out = 1'b0;
    strobe_out        = 1'b0;
    data_out          = 8'h00;
  end

  // clock only runs inside a write; data scrambled once the edge is past
  task automatic edge_out(input logic [7:0] d);
    data_out = d;
    #16 word_load_clk_out = 1'b1;
    #16 word_load_clk_out = 1'b0;
    data_out = ~d;
  endtask

  // link clock stands still: no stray byte write or serial shift in the sync lag
  task automatic strobe_only();
    strobe_out = 1'b1;
    #96 strobe_out = 1'b0;
    #64;
  endtask

  // extra edges needed so the synced strobe rewinds the pointer
  task automatic pulse_strobe();
    strobe_out = 1'b1;
    repeat (3) edge_out(data_out);
    strobe_out = 1'b0;
    // swallowed by the sync lag
    repeat (2) edge_out(data_out);
  endtask
endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); \
  end \
end

module tb;
  import dds_tuning_word_loader_pkg::*;
  typedef struct packed {
    prog_word_t w;
    logic       run;
    logic       rsv;
  } row_t;

  logic       core_clk_in = 1'b0;
  logic       rstn_in     = 1'b0;
  logic       wclk;
  logic       strobe;
  logic [7:0] data;
  prog_word_t prog;
  logic       run;
  logic       rsv;
  logic       ser;
  int         error_cnt   = 0;
  int         check_count = 0;
  prog_word_t last_w;
  prog_word_t b_w;
  prog_word_t s_w;
  row_t       rows [5] = '{
    '{'{5'h15, 1'b0, 2'b00, 32'h1234_5678}, 1'b1, 1'b0},
    '{'{5'h1F, 1'b1, 2'b00, 32'hFFFF_FFFF}, 1'b0, 1'b0},
    '{'{5'h01, 1'b1, 2'b11, 32'h8000_0001}, 1'b0, 1'b0},
    '{'{5'h10, 1'b0, 2'b00, 32'h0000_FF00}, 1'b1, 1'b0},
    '{'{5'h00, 1'b0, 2'b00, 32'h0000_0000}, 1'b1, 1'b0}};

  always #25 core_clk_in = ~core_clk_in;

  host_loader host (
    .word_load_clk_out (wclk),
    .strobe_out        (strobe),
    .data_out          (data)
  );

  dds_tuning_word_loader dut (
    .core_clk_in                (core_clk_in),
    .rstn_in                    (rstn_in),
    .ce_in                      (1'b1),
    .word_load_clk_in           (wclk),
    .frequency_update_strobe_in (strobe),
    .data_in                    (data),
    .prog_out                   (prog),
    .synth_run_out              (run),
    .reserved_code_out          (rsv),
    .serial_mode_out            (ser)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic load_par(input prog_word_t w);
    for (int k = 0; k < 5; k++) begin
      host.edge_out(w[39-8*k -: 8]);
    end
  endtask

  // old word must still show before the 13-cycle pipe has run
  // link edges only where the pointer is done; else they would write or shift
  task automatic apply_chk(input prog_word_t w, input prog_word_t old, input bit link);
    if (link) begin
      host.pulse_strobe();
    end else begin
      host.strobe_only();
    end
    repeat (8) @(negedge core_clk_in);
    `CHK(prog, old)
    repeat (14) @(negedge core_clk_in);
    `CHK(prog, w)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (2) @(negedge core_clk_in);
    rstn_in = 1'b1;
    // two edges release the link side
    host.edge_out(8'h00);
    host.edge_out(8'h00);
    last_w = '0;
    foreach (rows[i]) begin
      load_par(rows[i].w);
      apply_chk(rows[i].w, last_w, 1'b1);
      `CHK({run, rsv, ser}, {rows[i].run, rows[i].rsv, 1'b0})
      last_w = rows[i].w;
      $display("row %0d done", i);
    end
    // sixth byte must not overwrite the first
    b_w = '{5'h0C, 1'b0, 2'b00, 32'h0BAD_F00D};
    load_par(b_w);
    host.edge_out(8'hA5);
    apply_chk(b_w, last_w, 1'b1);
    $display("extra byte test done");
    // reset mid-run off the link clock; input register survives
    @(negedge core_clk_in);
    rstn_in = 1'b0;
    #1 `CHK({prog, run}, {40'h00_0000_0000, 1'b1})
    repeat (5) @(negedge core_clk_in);
    rstn_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    apply_chk(b_w, '0, 1'b0);
    $display("reset test done");
    // link release edges, then a full word whose first byte ends 011
    host.edge_out(8'h00);
    host.edge_out(8'h00);
    s_w = '{5'h06, 1'b0, 2'b11, 32'h0BAD_F00D};
    load_par(s_w);
    apply_chk(s_w, b_w, 1'b1);
    `CHK({run, rsv, ser}, 3'b101)
    last_w = s_w;
    s_w = '{5'h0A, 1'b1, 2'b00, 32'hCAFE_F00D};
    for (int i = 0; i < 40; i++) begin
      host.edge_out({s_w[i], 7'h00});
    end
    apply_chk(s_w, last_w, 1'b0);
    `CHK({run, rsv}, 2'b00)
    $display("serial test done");
    conclude();
  end

  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule

`default_nettype wire

// ---- verilog/dds_tuning_word_loader.sv ----
// Summary of operation
// - hold 40-bit word, parallel or serial load
// - five bytes on 8-bit bus form word
// - update strobe rise applies word, resets pointer
// - load clock captures byte, advances pointer
// - after five bytes, load edges are ignored
// - serial: load clock shifts one bit in
// - serial order tuning lsb-first, control, pd, phase
// - reset clears active word, pointer; 13-cycle latency
`include "dds_tuning_word_loader_map.svh"
`timescale 1ns/10ps
`default_nettype none

module dds_tuning_word_loader (
  // reference clock domain
  input  wire logic                                  core_clk_in,
  input  wire logic                                  rstn_in,
  input  wire logic                                  ce_in,
  // load pins
  input  wire logic                                  word_load_clk_in,
  input  wire logic                                  frequency_update_strobe_in,
  input  wire logic [7:0]                            data_in,
  // applied word and status
  output dds_tuning_word_loader_pkg::prog_word_t     prog_out,
  output logic                                       synth_run_out,
  output logic                                       reserved_code_out,
  output logic                                       serial_mode_out
);
  import dds_tuning_word_loader_pkg::*;

  // ****************************************
  // link domain: reset release and strobe sync
  // ****************************************
  logic             rst_l1;
  logic             link_rstn;
  logic             fq_l1;
  logic             fq_l2;
  logic             serial_data_input;
  ptr_t             ptr;
  ptr_t             next_ptr;
  logic             serial_mode;
  logic             next_serial;
  logic             ser_req;
  logic             next_ser_req;
  logic [`WORD_W-1:0] in_word;
  logic [`WORD_W-1:0] next_word;

  assign serial_data_input = data_in[`SERIAL_DATA_BIT];

  // release must be synchronous to the load clock, assertion is not
  always_ff @(posedge word_load_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_l1    <= 1'b0;
      link_rstn <= 1'b0;
    end else begin
      rst_l1    <= 1'b1;
      link_rstn <= rst_l1;
    end
  end

  always_ff @(posedge word_load_clk_in or negedge link_rstn) begin
    if (!link_rstn) begin
      fq_l1 <= 1'b0;
      fq_l2 <= 1'b0;
    end else begin
      fq_l1 <= frequency_update_strobe_in;
      fq_l2 <= fq_l1;
    end
  end

  function automatic int byte_idx(input ptr_t p);
    unique case (p)
      P_B0:    byte_idx = 0;
      P_B1:    byte_idx = 1;
      P_B2:    byte_idx = 2;
      P_B3:    byte_idx = 3;
      P_B4:    byte_idx = 4;
      default: byte_idx = `BYTE_COUNT;
    endcase
  endfunction

  // ****************************************
  // link domain: byte pointer and load mode
  // ****************************************
  // load edges seen while the synced strobe fq_l2 is high only rewind the pointer and take up any serial request
  always_comb begin
    next_ptr     = ptr;
    next_serial  = serial_mode;
    next_ser_req = ser_req;
    if (fq_l2) begin
      next_ptr     = P_B0;
      next_ser_req = 1'b0;
      if (ser_req) begin
        next_serial = 1'b1;
      end
    end else if (!serial_mode) begin
      unique case (ptr)
        P_B0: begin
          next_ptr     = P_B1;
          next_ser_req = (data_in[2:0] == `SERIAL_SWITCH_CODE);
        end
        P_B1:    next_ptr = P_B2;
        P_B2:    next_ptr = P_B3;
        P_B3:    next_ptr = P_B4;
        P_B4:    next_ptr = P_DONE;
        P_DONE:  next_ptr = P_DONE;
        default: next_ptr = P_B0;
      endcase
    end
  end

  always_ff @(posedge word_load_clk_in or negedge link_rstn) begin
    if (!link_rstn) begin
      ptr         <= P_B0;
      serial_mode <= 1'b0;
      ser_req     <= 1'b0;
    end else begin
      ptr         <= next_ptr;
      serial_mode <= next_serial;
      ser_req     <= next_ser_req;
    end
  end

  // ****************************************
  // link domain: input data register
  // ****************************************
  // bytes land msb-first, so byte k sits just below byte k-1
  always_comb begin
    next_word = in_word;
    if (!fq_l2 && serial_mode) begin
      next_word = {serial_data_input, in_word[`WORD_W-1:1]};
    end else if (!fq_l2 && ptr != P_DONE) begin
      next_word[`WORD_W-1-`BYTE_W*byte_idx(ptr) -: `BYTE_W] = data_in;
    end
  end

  // not reset: master reset leaves the input register alone
  always_ff @(posedge word_load_clk_in) begin
    in_word <= next_word;
  end

  assign serial_mode_out = serial_mode;

  // ****************************************
  // core domain: strobe sync and apply
  // ****************************************
  logic             fq_c1;
  logic             fq_c2;
  logic             fq_c3;
  logic             next_fq_c1;
  logic             next_fq_c2;
  logic             next_fq_c3;
  logic             fq_rise;
  prog_word_t       active;
  prog_word_t       next_active;
  prog_word_t       pipe [0:`OUT_LATENCY_CYCLES-1];
  prog_word_t       next_pipe [0:`OUT_LATENCY_CYCLES-1];
  logic             up_q;

  assign fq_rise = fq_c2 && !fq_c3;

  // the input register is quiet only once fq_l2 is high or the parallel pointer is done; otherwise the two load edges of the sync lag
  // can still write or shift it, so the load clock must stand still there before it is taken across
  always_comb begin
    next_fq_c1  = fq_c1;
    next_fq_c2  = fq_c2;
    next_fq_c3  = fq_c3;
    next_active = active;
    for (int k = 0; k < `OUT_LATENCY_CYCLES; k++) begin
      next_pipe[k] = pipe[k];
    end
    if (ce_in) begin
      next_fq_c1 = frequency_update_strobe_in;
      next_fq_c2 = fq_c1;
      next_fq_c3 = fq_c2;
      if (fq_rise) begin
        next_active = prog_word_t'(in_word);
      end
      next_pipe[0] = active;
      for (int k = 1; k < `OUT_LATENCY_CYCLES; k++) begin
        next_pipe[k] = pipe[k-1];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fq_c1  <= 1'b0;
      fq_c2  <= 1'b0;
      fq_c3  <= 1'b0;
      active <= prog_word_t'(`ACTIVE_RESET);
      up_q   <= 1'b0;
      for (int k = 0; k < `OUT_LATENCY_CYCLES; k++) begin
        pipe[k] <= prog_word_t'(`ACTIVE_RESET);
      end
    end else begin
      fq_c1  <= next_fq_c1;
      fq_c2  <= next_fq_c2;
      fq_c3  <= next_fq_c3;
      active <= next_active;
      up_q   <= 1'b1;
      for (int k = 0; k < `OUT_LATENCY_CYCLES; k++) begin
        pipe[k] <= next_pipe[k];
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prog_out          = pipe[`OUT_LATENCY_CYCLES-1];
  // test codes 01 and 10 halt the datapath as well
  assign reserved_code_out = ^prog_out.control;
  assign synth_run_out     = !prog_out.power_down && !reserved_code_out;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_ce13;
    ce_in [*8] ##1 ce_in [*5];
  endsequence

  sequence s_five_bytes;
    (ptr == P_B4 && !fq_l2 && !serial_mode);
  endsequence

  property p_apply;
    @(posedge core_clk_in) disable iff (!rstn_in)
    fq_rise && ce_in |=> active == prog_word_t'($past(in_word));
  endproperty
  a_apply: assert property (p_apply) else $error("word not applied on strobe");

  property p_latency;
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_ce13 |=> prog_out == $past(active, 13);
  endproperty
  a_latency: assert property (p_latency) else $error("output latency wrong");

  property p_reset_clear;
    @(posedge core_clk_in) disable iff (!rstn_in)
    !up_q |-> active == prog_word_t'(`ACTIVE_RESET) && prog_out == prog_word_t'(`ACTIVE_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear word");

  property p_power;
    @(posedge core_clk_in) disable iff (!rstn_in)
    prog_out.power_down |-> !synth_run_out;
  endproperty
  a_power: assert property (p_power) else $error("synthesis runs in power-down");

  property p_first_byte;
    @(posedge word_load_clk_in) disable iff (!link_rstn)
    ptr == P_B0 && !fq_l2 && !serial_mode |=> in_word[`WORD_W-1 -: `BYTE_W] == $past(data_in) && ptr == P_B1;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte misplaced");

  property p_last_byte;
    @(posedge word_load_clk_in) disable iff (!link_rstn)
    s_five_bytes |=> in_word[`BYTE_W-1:0] == $past(data_in) && ptr == P_DONE;
  endproperty
  a_last_byte: assert property (p_last_byte) else $error("fifth byte misplaced");

  property p_ignore;
    @(posedge word_load_clk_in) disable iff (!link_rstn)
    ptr == P_DONE && !fq_l2 && !serial_mode |=> ptr == P_DONE && $stable(in_word);
  endproperty
  a_ignore: assert property (p_ignore) else $error("load edge not ignored");

  property p_shift;
    @(posedge word_load_clk_in) disable iff (!link_rstn)
    serial_mode && !fq_l2 |=> in_word == {$past(serial_data_input), $past(in_word[`WORD_W-1:1])};
  endproperty
  a_shift: assert property (p_shift) else $error("serial shift wrong");

  property p_rewind;
    @(posedge word_load_clk_in) disable iff (!link_rstn)
    fq_l2 |=> ptr == P_B0 && $stable(in_word);
  endproperty
  a_rewind: assert property (p_rewind) else $error("pointer not rewound");

  property p_serial_entry;
    @(posedge word_load_clk_in) disable iff (!link_rstn)
    fq_l2 && ser_req |=> serial_mode ##1 serial_mode;
  endproperty
  a_serial_entry: assert property (p_serial_entry) else $error("serial mode not entered");

endmodule

`default_nettype wire

// ---- verilog/dds_tuning_word_loader_map.svh ----
`ifndef DDS_TUNING_WORD_LOADER_MAP_SVH
`define DDS_TUNING_WORD_LOADER_MAP_SVH
// ****************************************
// word layout
// ****************************************
`define WORD_W              40
`define BYTE_W              8
`define BYTE_COUNT          5
`define TUNING_LSB          0
`define CTL_LSB             32
`define PD_BIT              34
`define PHASE_LSB           35
`define SERIAL_DATA_BIT     7
`define SERIAL_SWITCH_CODE  3'h3
`define ACTIVE_RESET        40'h00_0000_0000
// ****************************************
// timing in reference clock cycles
// ****************************************
`define OUT_LATENCY_CYCLES  13
`define RESET_MIN_CYCLES    5
`define RESET_RECOVERY_CYC  2
`endif

// ---- verilog/dds_tuning_word_loader_pkg.sv ----
package dds_tuning_word_loader_pkg;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [4:0]  phase;
    logic        power_down;
    logic [1:0]  control;
    logic [31:0] tuning;
  } prog_word_t;

  // gray codes along the byte sequence
  typedef enum logic [2:0] {
    P_B0   = 3'h0,
    P_B1   = 3'h1,
    P_B2   = 3'h3,
    P_B3   = 3'h2,
    P_B4   = 3'h6,
    P_DONE = 3'h7
  } ptr_t;
endpackage
